// [sma_consts.svh]
// Purpose: offsets, field positions, reset values and timing of the status aggregator
// Assumes: APB byte addresses, 32-bit words, 40 MHz pclk
// Notes: Overview of operation listed below
//
// Overview of operation
// - each active condition drives overall or individual status by output mode.
// - status goes both to the indicator LEDs and to digital outputs.
// - a new message sets a flashing pending indicator and offers the summary.
// - each message has a log enable; transient messages are not logged.
// - a control bit selects overall status or individual status output.
// - individual mode maps messages onto failure, maintenance and function check.
// - failure marks value invalid; function check marks value discard.
// - individual status is system wide; optionally split per module group.
// - messages from I/O devices feed only the system wide signals.
// - error LED shows overall or failure; maintenance LED shows maintenance only.
// - each message has exactly one of three handling categories.
// - no-ack messages set and clear LED, signal and pending with the condition.
// - ack messages clear signal with condition; pending waits for acknowledge.
// - ack-plus-intervention clears everything once acknowledged and cause removed.
// - each message holds four attribute bits: overall, failure, maintenance, function check.
// - the message number of each message is readable for the summary line.
`ifndef SMA_CONSTS_SVH
`define SMA_CONSTS_SVH
`define SMA_ADDR_CTRL 8'h00
`define SMA_ADDR_IRQ_STAT 8'h04
`define SMA_ADDR_IRQ_MASK 8'h08
`define SMA_ADDR_STATUS 8'h0c
`define SMA_ADDR_ACK 8'h10
`define SMA_ADDR_PEND 8'h14
`define SMA_ADDR_ACTIVE 8'h18
`define SMA_ADDR_LAST_NEW 8'h1c
`define SMA_ADDR_LAST_LOG 8'h20
`define SMA_CFG_PAGE 2'h1
`define SMA_CTRL_MODE 0
`define SMA_CTRL_SPLIT 1
`define SMA_IRQ_NEW 0
`define SMA_IRQ_LOG 1
`define SMA_IRQ_ACK 2
`define SMA_CFG_CAT_LSB 0
`define SMA_CFG_ATTR_S 2
`define SMA_CFG_ATTR_A 3
`define SMA_CFG_ATTR_W 4
`define SMA_CFG_ATTR_F 5
`define SMA_CFG_LOG_EN 6
`define SMA_CFG_IO_DEV 7
`define SMA_CFG_GRP_LSB 8
`define SMA_CFG_NUM_LSB 16
`define SMA_CFG_RST 32'h00000040
`define SMA_CTRL_RST 2'h0
`define SMA_MASK_RST 3'h0
`define SMA_BLINK_MS 500
`define SMA_CLK_KHZ 40000
`endif

// [sma_pkg.sv]
// Purpose: shared types of the status aggregator
// Assumes: nothing
// Notes: category code 3 is handled as acknowledge plus intervention
package sma_pkg;
    typedef enum logic [1:0] {
        SMA_CAT_NONE,
        SMA_CAT_ACK,
        SMA_CAT_INTV
    } sma_cat_t;
    typedef logic [15:0] sma_num_t;
endpackage : sma_pkg

// [sma_aggregator.sv]
// Purpose: per-message status latches, status outputs, LEDs, log strobe, APB slave
// Assumes: condition inputs share pclk; ack_pin is asynchronous
// Notes: APB answers in the access cycle right after setup, no wait states
//
// Design decisions made here: register access over APB and the address map.
`include "sma_consts.svh"
module sma_aggregator #(
    parameter int NUM_MSG = 8,
    parameter int NUM_GRP = 4,
    parameter int unsigned BLINK_CYC = `SMA_BLINK_MS * `SMA_CLK_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_MSG-1:0] cond_in,
    input wire logic ack_pin,
    output logic led_error,
    output logic led_maint,
    output logic pend_flash,
    output logic summary_en,
    output logic dout_overall,
    output logic dout_fail,
    output logic dout_maint,
    output logic dout_fcheck,
    output logic [NUM_GRP-1:0] grp_fail,
    output logic [NUM_GRP-1:0] grp_maint,
    output logic [NUM_GRP-1:0] grp_fcheck,
    output logic val_invalid,
    output logic val_discard,
    output logic log_strobe,
    output logic [15:0] log_num,
    output logic irq
);

    typedef struct packed {
        logic [NUM_MSG-1:0] act;
        logic [NUM_MSG-1:0] pend;
        logic [NUM_MSG-1:0] ackd;
        logic [NUM_MSG-1:0] logq;
        logic [NUM_MSG-1:0][31:0] cfg;
        logic mode;
        logic split;
        logic [2:0] irq_mask;
        logic [2:0] irq_stat;
        logic [15:0] last_new;
        logic [2:0] sync;
        logic ack_lvl;
        logic [31:0] blink_cnt;
        logic blink;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic led_error;
        logic led_maint;
        logic pend_flash;
        logic summary_en;
        logic dout_overall;
        logic dout_fail;
        logic dout_maint;
        logic dout_fcheck;
        logic [NUM_GRP-1:0] grp_fail;
        logic [NUM_GRP-1:0] grp_maint;
        logic [NUM_GRP-1:0] grp_fcheck;
        logic val_invalid;
        logic val_discard;
        logic log_strobe;
        logic [15:0] log_num;
        logic irq;
    } sma_state_t;

    sma_state_t st;
    sma_state_t next_st;

    // helper vectors, also watched by the checks
    logic [NUM_MSG-1:0] rise_v;
    logic [NUM_MSG-1:0] ack_v;
    logic [NUM_MSG-1:0] sig_v;
    logic [NUM_MSG-1:0] none_v;
    logic [NUM_MSG-1:0] intv_v;
    logic [NUM_MSG-1:0] logen_v;
    logic ack_ev;
    logic wr_en;
    logic setup;

    // next state of every register
    always_comb begin
        logic [NUM_MSG-1:0] emit;
        logic [2:0] ev;
        logic [2:0] clr;
        logic [3:0] idx;
        logic cfg_hit;
        logic found;
        logic any_s;
        logic any_a;
        logic any_w;
        logic any_f;
        logic [31:0] rd;
        sma_pkg::sma_cat_t cat;
        emit = '0;
        ev = '0;
        clr = '0;
        idx = paddr[5:2];
        cfg_hit = (paddr[7:6] == `SMA_CFG_PAGE) && (int'(idx) < NUM_MSG);
        found = 1'b0;
        any_s = 1'b0;
        any_a = 1'b0;
        any_w = 1'b0;
        any_f = 1'b0;
        rd = '0;
        cat = sma_pkg::SMA_CAT_NONE;
        next_st = st;
        setup = psel && !penable;
        wr_en = psel && penable && st.pready && pwrite;

        // three-stage pin sync; level changes once stages two and three agree
        next_st.sync = {st.sync[1:0], ack_pin};
        if (st.sync[2] == st.sync[1]) begin
            next_st.ack_lvl = st.sync[2];
        end
        ack_ev = st.sync[2] && st.sync[1] && !st.ack_lvl;

        // per-message latches
        for (int i = 0; i < NUM_MSG; i++) begin
            cat = sma_pkg::sma_cat_t'(st.cfg[i][`SMA_CFG_CAT_LSB +: 2]);
            none_v[i] = (cat == sma_pkg::SMA_CAT_NONE);
            intv_v[i] = !none_v[i] && (cat != sma_pkg::SMA_CAT_ACK);
            logen_v[i] = st.cfg[i][`SMA_CFG_LOG_EN];
            rise_v[i] = cond_in[i] && !st.act[i];
            ack_v[i] = st.pend[i] && (ack_ev || (wr_en && paddr == `SMA_ADDR_ACK
                && pwdata[i]));
            next_st.act[i] = cond_in[i];
            if (none_v[i]) begin
                next_st.pend[i] = cond_in[i];
            end else if (rise_v[i]) begin
                next_st.pend[i] = 1'b1;
            end else if ((st.ackd[i] || ack_v[i]) && !cond_in[i]) begin
                next_st.pend[i] = 1'b0;
            end
            if (rise_v[i] || !next_st.pend[i]) begin
                next_st.ackd[i] = 1'b0;
            end else if (ack_v[i]) begin
                next_st.ackd[i] = 1'b1;
            end
            // intervention kind holds the signal until ack and cause removal
            if (intv_v[i]) begin
                sig_v[i] = next_st.act[i] || next_st.pend[i];
            end else begin
                sig_v[i] = next_st.act[i];
            end
        end

        // system wide status as the OR of all messages
        for (int i = 0; i < NUM_MSG; i++) begin
            any_s = any_s || (sig_v[i] && st.cfg[i][`SMA_CFG_ATTR_S]);
            any_a = any_a || (sig_v[i] && st.cfg[i][`SMA_CFG_ATTR_A]);
            any_w = any_w || (sig_v[i] && st.cfg[i][`SMA_CFG_ATTR_W]);
            any_f = any_f || (sig_v[i] && st.cfg[i][`SMA_CFG_ATTR_F]);
        end
        next_st.dout_overall = !st.mode && any_s;
        next_st.dout_fail = st.mode && any_a;
        next_st.dout_maint = st.mode && any_w;
        next_st.dout_fcheck = st.mode && any_f;
        next_st.val_invalid = st.mode && any_a;
        next_st.val_discard = st.mode && any_f;
        next_st.led_error = st.mode ? any_a : any_s;
        next_st.led_maint = st.mode && any_w;
        next_st.summary_en = |next_st.pend;

        // per-group outputs, I/O device messages excluded
        for (int g = 0; g < NUM_GRP; g++) begin
            next_st.grp_fail[g] = 1'b0;
            next_st.grp_maint[g] = 1'b0;
            next_st.grp_fcheck[g] = 1'b0;
            for (int i = 0; i < NUM_MSG; i++) begin
                if (st.mode && st.split && sig_v[i] && !st.cfg[i][`SMA_CFG_IO_DEV]
                    && st.cfg[i][`SMA_CFG_GRP_LSB +: 2] == 2'(g)) begin
                    next_st.grp_fail[g] = next_st.grp_fail[g]
                        || st.cfg[i][`SMA_CFG_ATTR_A];
                    next_st.grp_maint[g] = next_st.grp_maint[g]
                        || st.cfg[i][`SMA_CFG_ATTR_W];
                    next_st.grp_fcheck[g] = next_st.grp_fcheck[g]
                        || st.cfg[i][`SMA_CFG_ATTR_F];
                end
            end
        end

        // flashing pending indicator
        if (st.blink_cnt >= BLINK_CYC - 1) begin
            next_st.blink_cnt = '0;
            next_st.blink = !st.blink;
        end else begin
            next_st.blink_cnt = st.blink_cnt + 32'h1;
        end
        next_st.pend_flash = (|next_st.pend) && next_st.blink;

        // newest message number and log queue, lowest index first
        for (int i = 0; i < NUM_MSG; i++) begin
            if (rise_v[i] && !found) begin
                next_st.last_new = st.cfg[i][`SMA_CFG_NUM_LSB +: 16];
                found = 1'b1;
            end
        end
        found = 1'b0;
        next_st.log_strobe = 1'b0;
        for (int i = 0; i < NUM_MSG; i++) begin
            if (st.logq[i] && !found) begin
                emit[i] = 1'b1;
                found = 1'b1;
                next_st.log_strobe = 1'b1;
                next_st.log_num = st.cfg[i][`SMA_CFG_NUM_LSB +: 16];
            end
        end
        next_st.logq = (st.logq & ~emit) | (rise_v & logen_v);

        // interrupt status, set wins over write-one clear
        ev[`SMA_IRQ_NEW] = |rise_v;
        ev[`SMA_IRQ_LOG] = |emit;
        ev[`SMA_IRQ_ACK] = |ack_v;
        if (wr_en && paddr == `SMA_ADDR_IRQ_STAT) begin
            clr = pwdata[2:0];
        end
        next_st.irq_stat = (st.irq_stat & ~clr) | ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        // register writes at the access edge
        if (wr_en) begin
            if (paddr == `SMA_ADDR_CTRL) begin
                next_st.mode = pwdata[`SMA_CTRL_MODE];
                next_st.split = pwdata[`SMA_CTRL_SPLIT];
            end
            if (paddr == `SMA_ADDR_IRQ_MASK) begin
                next_st.irq_mask = pwdata[2:0];
            end
            if (cfg_hit) begin
                next_st.cfg[idx] = pwdata;
            end
        end

        // read data prepared in the setup cycle
        case (paddr)
            `SMA_ADDR_CTRL: rd = {30'h0, st.split, st.mode};
            `SMA_ADDR_IRQ_STAT: rd = {29'h0, st.irq_stat};
            `SMA_ADDR_IRQ_MASK: rd = {29'h0, st.irq_mask};
            `SMA_ADDR_STATUS: rd = {24'h0, st.val_discard, st.val_invalid,
                st.dout_fcheck, st.dout_maint, st.dout_fail, st.dout_overall,
                st.pend_flash, st.summary_en};
            `SMA_ADDR_PEND: rd[NUM_MSG-1:0] = st.pend;
            `SMA_ADDR_ACTIVE: rd[NUM_MSG-1:0] = st.act;
            `SMA_ADDR_LAST_NEW: rd = {16'h0, st.last_new};
            `SMA_ADDR_LAST_LOG: rd = {16'h0, st.log_num};
            default: rd = cfg_hit ? st.cfg[idx] : 32'h0;
        endcase
        next_st.pready = setup;
        next_st.pslverr = 1'b0;
        if (setup) begin
            next_st.prdata = rd;
            next_st.pslverr = !(cfg_hit || paddr == `SMA_ADDR_CTRL
                || paddr == `SMA_ADDR_IRQ_STAT || paddr == `SMA_ADDR_IRQ_MASK
                || paddr == `SMA_ADDR_STATUS || paddr == `SMA_ADDR_ACK
                || paddr == `SMA_ADDR_PEND || paddr == `SMA_ADDR_ACTIVE
                || paddr == `SMA_ADDR_LAST_NEW || paddr == `SMA_ADDR_LAST_LOG);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.mode <= 1'(`SMA_CTRL_RST >> `SMA_CTRL_MODE);
            st.split <= 1'(`SMA_CTRL_RST >> `SMA_CTRL_SPLIT);
            st.irq_mask <= `SMA_MASK_RST;
            for (int i = 0; i < NUM_MSG; i++) begin
                st.cfg[i] <= `SMA_CFG_RST;
            end
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign led_error = st.led_error;
    assign led_maint = st.led_maint;
    assign pend_flash = st.pend_flash;
    assign summary_en = st.summary_en;
    assign dout_overall = st.dout_overall;
    assign dout_fail = st.dout_fail;
    assign dout_maint = st.dout_maint;
    assign dout_fcheck = st.dout_fcheck;
    assign grp_fail = st.grp_fail;
    assign grp_maint = st.grp_maint;
    assign grp_fcheck = st.grp_fcheck;
    assign val_invalid = st.val_invalid;
    assign val_discard = st.val_discard;
    assign log_strobe = st.log_strobe;
    assign log_num = st.log_num;
    assign irq = st.irq;

    // checks on one clock domain
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a rising condition leaves its message pending
    chk_pend_on_rise: assert property (
        (|rise_v) |=> ((st.pend & $past(rise_v)) == $past(rise_v)))
        else $error("new message not pending");

    // summary softkey follows a new message
    chk_summary_new: assert property (
        (|rise_v) |=> summary_en)
        else $error("summary not offered");

    // no-ack messages pending exactly while active
    chk_none_track: assert property (
        (((st.act ^ st.pend) & none_v) == '0) || $changed(st.cfg))
        else $error("no-ack pending differs from condition");

    // acked and ended message clears next cycle
    chk_ack_clear: assert property (
        (|(ack_v & ~none_v & ~cond_in)) |=>
        ((st.pend & $past(ack_v & ~none_v & ~cond_in)) == '0))
        else $error("acked message still pending");

    // unacked intervention message stays pending whatever its condition does
    chk_intv_hold: assert property (
        (|(intv_v & st.pend & ~st.ackd & ~ack_v)) |=>
        ((st.pend & $past(intv_v & st.pend & ~st.ackd & ~ack_v))
            == $past(intv_v & st.pend & ~st.ackd & ~ack_v)))
        else $error("intervention message dropped before ack");

    // overall mode drives no individual output
    chk_mode_overall: assert property (
        !st.mode && !$past(st.mode) |=> !dout_fail && !dout_maint && !dout_fcheck)
        else $error("individual output in overall mode");

    // maintenance LED only in individual mode
    chk_maint_led: assert property (
        led_maint |-> $past(st.mode))
        else $error("maintenance LED in overall mode");

    // groups stay off unless split
    chk_split_off: assert property (
        !st.split |=> (grp_fail == '0) && (grp_maint == '0) && (grp_fcheck == '0))
        else $error("group output without split");

    // log strobe only for log-enabled messages
    chk_log_gate: assert property (
        ((st.logq & ~logen_v) == '0) || $changed(st.cfg))
        else $error("transient message queued for log");

    // value marking follows failure and function check and needs a live or pending message
    chk_value_marks: assert property (
        (val_invalid == dout_fail) && (val_discard == dout_fcheck)
        && (!(val_invalid || val_discard) || $past(st.mode && (|(cond_in | st.pend)))))
        else $error("value marking mismatch");

    // apb answers one cycle after setup
    chk_apb_ready: assert property (
        setup |=> pready ##1 !pready)
        else $error("apb ready timing");

    cov_new_msg: cover property ((|rise_v) ##[1:20] (|ack_v));
    cov_log: cover property (log_strobe);
    cov_pin_ack: cover property (ack_ev);
    cov_slverr: cover property (pslverr && pready);

endmodule : sma_aggregator

// [sma_panel.sv]
// Purpose: operator panel model that presses the acknowledge key
// Assumes: one press at a time, pclk domain, key idles low
// Notes: key goes down after a chosen delay and is held four cycles
module sma_panel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic press,
    input wire logic [3:0] dly,
    output logic ack_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;
    // count the delay down, then the key stays pressed for the last four counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 5'h00;
        end else if (press && cnt == 5'h00) begin
            cnt <= {1'b0, dly} + 5'h05;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end
    end
    // key level, released to low between presses
    assign ack_pin = (cnt != 5'h00) && (cnt < 5'h05);
endmodule : sma_panel

// [test_status_message_aggregator.sv]
// Purpose: self-checking bench of the status aggregator
// Assumes: blink half period shortened to 8 cycles, eight messages
// Notes: each scenario is one task; the panel model presses acknowledge
`include "sma_consts.svh"
module test_status_message_aggregator;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] cond_in = 8'h00;
    logic press = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, serr, ack_pin, led_error, led_maint, pend_flash, summary_en;
    logic dout_overall, dout_fail, dout_maint, dout_fcheck, val_invalid, val_discard;
    logic log_strobe, irq;
    logic [3:0] grp_fail, grp_maint, grp_fcheck;
    logic [15:0] log_num, last_log;
    logic [7:0] ov;
    int checked = 0;
    int error_cnt = 0;
    int logs = 0;
    sma_aggregator #(.NUM_MSG(8), .NUM_GRP(4), .BLINK_CYC(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cond_in(cond_in), .ack_pin(ack_pin), .led_error(led_error), .led_maint(led_maint),
        .pend_flash(pend_flash), .summary_en(summary_en), .dout_overall(dout_overall),
        .dout_fail(dout_fail), .dout_maint(dout_maint), .dout_fcheck(dout_fcheck),
        .grp_fail(grp_fail), .grp_maint(grp_maint), .grp_fcheck(grp_fcheck),
        .val_invalid(val_invalid), .val_discard(val_discard), .log_strobe(log_strobe),
        .log_num(log_num), .irq(irq));
    sma_panel panel_u (.pclk(pclk), .presetn(presetn), .press(press), .dly(dly),
        .ack_pin(ack_pin));
    // shared status outputs packed for compact comparison
    assign ov = {val_discard, val_invalid, dout_fcheck, dout_maint, dout_fail, dout_overall,
        led_maint, led_error};
    // clock and log strobe counter
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (log_strobe === 1'b1) begin
            logs <= logs + 1;
            last_log <= log_num;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    // one APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic setc(input int i, input logic v);
        @(posedge pclk);
        cond_in[i] <= v;
        repeat (5) @(posedge pclk);
        #1;
    endtask : setc
    task automatic push(input logic [3:0] d);
        @(posedge pclk);
        press <= 1'b1;
        dly <= d;
        @(posedge pclk);
        press <= 1'b0;
    endtask : push
    task automatic wait_sum(input logic v);
        int n;
        n = 0;
        while (summary_en !== v && n < 64) begin
            @(posedge pclk);
            n++;
        end
        chk(summary_en, v);
    endtask : wait_sum
    task automatic t_reset();
        apb(1'b0, `SMA_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `SMA_ADDR_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, `SMA_CFG_RST);
        apb(1'b0, 8'h30, 32'h0);
        chk(serr, 1'b1);
        chk(rd, 32'h0);
        chk(ov, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_noack();
        int hi;
        hi = 0;
        apb(1'b1, 8'h40, 32'h0065_0044);
        setc(0, 1'b1);
        chk(ov, 8'h05);
        chk(summary_en, 1'b1);
        chk(logs, 1);
        chk(last_log, 16'h0065);
        apb(1'b0, `SMA_ADDR_LAST_NEW, 32'h0);
        chk(rd, 32'h0000_0065);
        apb(1'b0, `SMA_ADDR_LAST_LOG, 32'h0);
        chk(rd, 32'h0000_0065);
        for (int c = 0; c < 32; c++) begin
            @(posedge pclk);
            hi += (pend_flash === 1'b1);
        end
        chk(hi > 0 && hi < 32, 1'b1);
        setc(0, 1'b0);
        chk(ov, 8'h00);
        chk(summary_en, 1'b0);
        $display("t_noack done");
    endtask : t_noack
    task automatic t_nolog();
        apb(1'b1, 8'h44, 32'h0070_0004);
        setc(1, 1'b1);
        chk(logs, 1);
        chk(ov, 8'h05);
        setc(1, 1'b0);
        $display("t_nolog done");
    endtask : t_nolog
    task automatic t_indiv();
        apb(1'b1, `SMA_ADDR_CTRL, 32'h1);
        apb(1'b1, 8'h48, 32'h0000_0058);
        apb(1'b1, 8'h4c, 32'h0000_0060);
        setc(2, 1'b1);
        chk(ov, 8'h5b);
        setc(3, 1'b1);
        chk(ov, 8'hfb);
        setc(2, 1'b0);
        chk(ov, 8'ha0);
        setc(3, 1'b0);
        chk(ov, 8'h00);
        $display("t_indiv done");
    endtask : t_indiv
    task automatic t_group();
        apb(1'b1, `SMA_ADDR_CTRL, 32'h3);
        apb(1'b1, 8'h50, 32'h0000_0238);
        apb(1'b1, 8'h54, 32'h0000_01b8);
        setc(5, 1'b1);
        chk({grp_fcheck, grp_maint, grp_fail}, 12'h000);
        chk(dout_fail, 1'b1);
        setc(4, 1'b1);
        chk({grp_fcheck, grp_maint, grp_fail}, 12'h444);
        apb(1'b1, `SMA_ADDR_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        chk({grp_fcheck, grp_maint, grp_fail}, 12'h000);
        setc(4, 1'b0);
        setc(5, 1'b0);
        apb(1'b1, `SMA_ADDR_CTRL, 32'h0);
        $display("t_group done");
    endtask : t_group
    task automatic t_ack();
        apb(1'b1, 8'h58, 32'h0000_0005);
        setc(6, 1'b1);
        setc(6, 1'b0);
        chk(ov, 8'h00);
        chk(summary_en, 1'b1);
        apb(1'b0, `SMA_ADDR_PEND, 32'h0);
        chk(rd, 32'h0000_0040);
        apb(1'b1, `SMA_ADDR_ACK, 32'h0000_0040);
        wait_sum(1'b0);
        setc(6, 1'b1);
        push(4'h1);
        repeat (20) @(posedge pclk);
        chk(summary_en, 1'b1);
        chk(ov, 8'h05);
        apb(1'b0, `SMA_ADDR_ACTIVE, 32'h0);
        chk(rd, 32'h0000_0040);
        setc(6, 1'b0);
        chk(summary_en, 1'b0);
        $display("t_ack done");
    endtask : t_ack
    task automatic t_intv();
        apb(1'b1, 8'h5c, 32'h0000_0006);
        setc(7, 1'b1);
        setc(7, 1'b0);
        chk(ov, 8'h05);
        chk(summary_en, 1'b1);
        apb(1'b0, `SMA_ADDR_STATUS, 32'h0);
        chk(rd & 32'hfd, 32'h05);
        push(4'h9);
        wait_sum(1'b0);
        chk(ov, 8'h00);
        $display("t_intv done");
    endtask : t_intv
    task automatic t_irq();
        apb(1'b1, `SMA_ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, `SMA_ADDR_IRQ_STAT, 32'h7);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        setc(0, 1'b1);
        chk(irq, 1'b1);
        apb(1'b0, `SMA_ADDR_IRQ_STAT, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, `SMA_ADDR_IRQ_STAT, 32'h7);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        setc(0, 1'b0);
        apb(1'b1, `SMA_ADDR_IRQ_MASK, 32'h0);
        setc(0, 1'b1);
        chk(irq, 1'b0);
        setc(0, 1'b0);
        $display("t_irq done");
    endtask : t_irq
    // reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_noack();
        t_nolog();
        t_indiv();
        t_group();
        t_ack();
        t_intv();
        t_irq();
        complete_run();
    end
endmodule : test_status_message_aggregator
